// ===== bsr_defs.svh
// constants for the brake sequencer and run logic
`ifndef BSR_DEFS_SVH
`define BSR_DEFS_SVH

// register byte offsets
`define BSR_OFS_CTRL 8'h00
`define BSR_OFS_MAG 8'h04
`define BSR_OFS_PRE 8'h08
`define BSR_OFS_POST 8'h0c
`define BSR_OFS_APPLY 8'h10
`define BSR_OFS_JOG 8'h14
`define BSR_OFS_STAT 8'h18

// control field positions
`define BSR_CTRL_BRAKE_EN 0
`define BSR_CTRL_MODE_LO 1
`define BSR_CTRL_MODE_HI 2
`define BSR_CTRL_SECURE 3
`define BSR_CTRL_JOG 4

// reset values
`define BSR_RST_DLY 16'h000a
`define BSR_RST_JOG 16'h0064

// timebase
`define BSR_CLK_NS 8
`define BSR_TICK_NS 1000000
`define BSR_TICK_CYC (`BSR_TICK_NS / `BSR_CLK_NS)

`endif

// ===== bsr_pkg.sv
// types for the brake sequencer and run logic
`default_nettype none
package bsr_pkg;
	// command decoding modes
	typedef enum logic [1:0] {
		BSR_MODE_LATCHED,
		BSR_MODE_PULSED,
		BSR_MODE_RUN_DIR,
		BSR_MODE_SPARE
	} bsr_mode_e;
	// brake sequence states
	typedef enum logic [2:0] {
		BSR_ST_OFF,
		BSR_ST_MAG,
		BSR_ST_POST,
		BSR_ST_RUN,
		BSR_ST_PRE,
		BSR_ST_APPLY
	} bsr_state_e;
	// contact inputs from the terminal block
	typedef struct packed {
		logic contact_input_two;
		logic contact_input_three;
		logic bidir_digital_line;
		logic safe_disable_input;
	} bsr_contacts_s;
	// drive outputs to the power stage and ramp
	typedef struct packed {
		logic brake_release;
		logic ramp_hold;
		logic drive_enable;
		logic run_fwd;
		logic run_rev;
		logic jog_active;
	} bsr_drive_s;
endpackage
`default_nettype wire

// ===== bsr_brake_run.sv
// brake sequencer and run/stop command decoder with apb registers
//
// Functional notes
// R1: with brake enabled and release conditions met, magnetisation delay starts first.
// R2: magnetisation delay expiry releases the brake output.
// R3: ramp held constant while magnetisation delay counts.
// R4: below apply threshold on stop, pre-apply delay postpones brake apply.
// R5: post-release delay starts at release; ramp stays locked until it ends.
// R6: brake apply delay keeps torque; at its end output stage turns off.
// R7: three command decoding modes are offered.
// R8: latched mode: input two forward, input three reverse, release stops.
// R9: pulsed mode: pulse two forward, bidir pulse reverse, input three stops.
// R10: pulsed mode reversal accepted only after a stop.
// R11: run-direction mode: input two run/stop, input three direction.
// R12: mode choice reassigns digital input functions automatically.
// R13: mode and safe-disable type change only with output disabled.
// R14: safe-disable input acts as unlock or as secure disable.
// R15: asserted jog input selects programmed jog speed as reference; here jog is ignored while a reverse run is decoded.
// R16: brake delays are down-counters on a fixed timebase tick.
// R17: below apply threshold without stop keeps brake control active.
`include "bsr_defs.svh"
`default_nettype none
module bsr_brake_run #(
	parameter int TICK_CYCLES = `BSR_TICK_CYC
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// apb slave
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// contacts and drive thresholds
	input wire bsr_pkg::bsr_contacts_s contacts,
	input wire logic release_ok,
	input wire logic below_apply,
	// drive outputs
	output bsr_pkg::bsr_drive_s drive,
	output logic [15:0] speed_ref
);
	import bsr_pkg::*;

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic brake_en;
		bsr_mode_e mode;
		logic secure;
		logic jog_sel;
		logic [15:0] mag_dly;
		logic [15:0] pre_dly;
		logic [15:0] post_dly;
		logic [15:0] apply_dly;
		logic [15:0] jog_speed;
		logic [16:0] tick_cnt;
		logic tick;
		logic [15:0] cnt;
		bsr_state_e state;
		logic in2_prev;
		logic dio_prev;
		bsr_drive_s drive;
		logic [15:0] speed_ref;
	} bsr_regs_s;

	bsr_regs_s st_r;
	bsr_regs_s st_nxt;

	// down-counter step on tick, saturating at zero
	function automatic logic [15:0] bsr_dec(input logic [15:0] v, input logic t);
		bsr_dec = (t && v != 16'h0000) ? v - 16'h0001 : v;
	endfunction

	// zero-extend a 16-bit field to a bus word
	function automatic logic [31:0] bsr_word(input logic [15:0] v);
		bsr_word = {16'h0000, v};
	endfunction

	// combinational helpers
	logic wr_en;
	logic rd_setup;
	logic hit;
	logic unlock;
	logic secure_off;
	logic run_req;
	logic expired;
	logic jog_in;
	logic in2_rise;
	logic dio_rise;

	// bus strobes and address decode
	assign wr_en = psel && penable && pwrite && st_r.pready;
	assign rd_setup = psel && !penable;
	assign hit = paddr == `BSR_OFS_CTRL || paddr == `BSR_OFS_MAG || paddr == `BSR_OFS_PRE ||
		paddr == `BSR_OFS_POST || paddr == `BSR_OFS_APPLY || paddr == `BSR_OFS_JOG || paddr == `BSR_OFS_STAT;

	// R14: unlock or secure disable
	assign unlock = st_r.secure || contacts.safe_disable_input;
	assign secure_off = st_r.secure && !contacts.safe_disable_input;
	// R12: bidir line is jog only outside pulsed mode
	assign jog_in = st_r.jog_sel && st_r.mode != BSR_MODE_PULSED && contacts.bidir_digital_line;
	assign in2_rise = contacts.contact_input_two && !st_r.in2_prev;
	assign dio_rise = contacts.bidir_digital_line && !st_r.dio_prev;
	// R16: delay ends on the tick seen at zero
	assign expired = st_r.tick && st_r.cnt == 16'h0000;

	// next-state logic
	always_comb begin
		st_nxt = st_r;
		st_nxt.in2_prev = contacts.contact_input_two;
		st_nxt.dio_prev = contacts.bidir_digital_line;
		// R16: fixed timebase tick
		st_nxt.tick = 1'b0;
		if (st_r.tick_cnt == 17'(TICK_CYCLES - 1)) begin
			st_nxt.tick_cnt = 17'h00000;
			st_nxt.tick = 1'b1;
		end else begin
			st_nxt.tick_cnt = st_r.tick_cnt + 17'h00001;
		end

		// apb answer one cycle after setup
		st_nxt.pready = rd_setup;
		st_nxt.pslverr = rd_setup && !hit;
		st_nxt.prdata = 32'h00000000;
		if (rd_setup && !pwrite) begin
			case (paddr)
				`BSR_OFS_CTRL: st_nxt.prdata = {27'h0000000, st_r.jog_sel, st_r.secure, st_r.mode, st_r.brake_en};
				`BSR_OFS_MAG: st_nxt.prdata = bsr_word(st_r.mag_dly);
				`BSR_OFS_PRE: st_nxt.prdata = bsr_word(st_r.pre_dly);
				`BSR_OFS_POST: st_nxt.prdata = bsr_word(st_r.post_dly);
				`BSR_OFS_APPLY: st_nxt.prdata = bsr_word(st_r.apply_dly);
				`BSR_OFS_JOG: st_nxt.prdata = bsr_word(st_r.jog_speed);
				`BSR_OFS_STAT: st_nxt.prdata = {20'h00000, 3'(st_r.state), 3'h0, st_r.drive};
				default: st_nxt.prdata = 32'h00000000;
			endcase
		end
		if (wr_en) begin
			case (paddr)
				`BSR_OFS_CTRL: begin
					st_nxt.jog_sel = pwdata[`BSR_CTRL_JOG];
					// R13: mode, input type and brake enable frozen while output enabled
					if (!st_r.drive.drive_enable) begin
						st_nxt.brake_en = pwdata[`BSR_CTRL_BRAKE_EN];
						st_nxt.mode = bsr_mode_e'(pwdata[`BSR_CTRL_MODE_HI:`BSR_CTRL_MODE_LO]);
						st_nxt.secure = pwdata[`BSR_CTRL_SECURE];
					end
				end
				`BSR_OFS_MAG: st_nxt.mag_dly = pwdata[15:0];
				`BSR_OFS_PRE: st_nxt.pre_dly = pwdata[15:0];
				`BSR_OFS_POST: st_nxt.post_dly = pwdata[15:0];
				`BSR_OFS_APPLY: st_nxt.apply_dly = pwdata[15:0];
				`BSR_OFS_JOG: st_nxt.jog_speed = pwdata[15:0];
				default: st_nxt.jog_speed = st_r.jog_speed;
			endcase
		end

		// R7: command decoding by mode
		case (st_r.mode)
			BSR_MODE_LATCHED: begin
				// R8: held contacts, release stops
				st_nxt.drive.run_fwd = contacts.contact_input_two && !contacts.contact_input_three;
				st_nxt.drive.run_rev = contacts.contact_input_three && !contacts.contact_input_two;
			end
			BSR_MODE_PULSED: begin
				// R9: pulses start, input three stops
				if (contacts.contact_input_three) begin
					st_nxt.drive.run_fwd = 1'b0;
					st_nxt.drive.run_rev = 1'b0;
				end else if (in2_rise && !st_r.drive.run_rev) begin
					// R10: no reversal without stop
					st_nxt.drive.run_fwd = 1'b1;
				end else if (dio_rise && !st_r.drive.run_fwd) begin
					st_nxt.drive.run_rev = 1'b1;
				end
			end
			BSR_MODE_RUN_DIR: begin
				// R11: run contact and direction contact
				st_nxt.drive.run_fwd = contacts.contact_input_two && !contacts.contact_input_three;
				st_nxt.drive.run_rev = contacts.contact_input_two && contacts.contact_input_three;
			end
			default: begin
				st_nxt.drive.run_fwd = 1'b0;
				st_nxt.drive.run_rev = 1'b0;
			end
		endcase
		// R15: jog runs forward at jog speed unless a reverse run is decoded
		st_nxt.drive.jog_active = jog_in && !(st_nxt.drive.run_rev);
		if (st_nxt.drive.jog_active) begin
			st_nxt.drive.run_fwd = 1'b1;
		end
		st_nxt.speed_ref = st_nxt.drive.jog_active ? st_r.jog_speed : 16'h0000;
		// decoded command gated by the unlock input, kept inside this process to avoid a loop
		run_req = (st_nxt.drive.run_fwd || st_nxt.drive.run_rev) && unlock;

		// brake sequence
		st_nxt.cnt = bsr_dec(st_r.cnt, st_r.tick);
		case (st_r.state)
			BSR_ST_OFF: begin
				if (run_req && !secure_off) begin
					// R1: magnetise before release
					st_nxt.state = st_r.brake_en ? BSR_ST_MAG : BSR_ST_RUN;
					st_nxt.cnt = st_r.mag_dly;
				end
			end
			BSR_ST_MAG: begin
				if (!run_req) begin
					st_nxt.state = BSR_ST_OFF;
				end else if (!release_ok) begin
					// R1: timer runs only with conditions met
					st_nxt.cnt = st_r.mag_dly;
				end else if (expired) begin
					// R2: release brake, R5: start post delay
					st_nxt.state = BSR_ST_POST;
					st_nxt.cnt = st_r.post_dly;
				end
			end
			BSR_ST_POST: begin
				// R5: ramp locked until expiry
				if (expired) begin
					st_nxt.state = BSR_ST_RUN;
				end
			end
			BSR_ST_RUN: begin
				// R4: stop below threshold; R17: no stop keeps brake open
				if (below_apply && !run_req) begin
					st_nxt.state = st_r.brake_en ? BSR_ST_PRE : BSR_ST_OFF;
					st_nxt.cnt = st_r.pre_dly;
				end
			end
			BSR_ST_PRE: begin
				if (run_req) begin
					st_nxt.state = BSR_ST_RUN;
				end else if (expired) begin
					// R6: apply brake and hold torque
					st_nxt.state = BSR_ST_APPLY;
					st_nxt.cnt = st_r.apply_dly;
				end
			end
			BSR_ST_APPLY: begin
				// R6: output off after apply delay
				if (expired) begin
					st_nxt.state = BSR_ST_OFF;
				end
			end
			default: st_nxt.state = BSR_ST_OFF;
		endcase
		// R14: secure disable cuts the output at once
		if (secure_off) begin
			st_nxt.state = BSR_ST_OFF;
		end

		// outputs follow the next state
		st_nxt.drive.drive_enable = st_nxt.state != BSR_ST_OFF;
		// brake output only exists while brake control is enabled
		st_nxt.drive.brake_release = st_nxt.brake_en &&
			(st_nxt.state == BSR_ST_POST || st_nxt.state == BSR_ST_RUN || st_nxt.state == BSR_ST_PRE);
		// R3: ramp frozen while magnetising and until post delay ends
		st_nxt.drive.ramp_hold = st_nxt.state == BSR_ST_MAG || st_nxt.state == BSR_ST_POST;
	end

	// state register
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			st_r <= '0;
			st_r.mag_dly <= `BSR_RST_DLY;
			st_r.pre_dly <= `BSR_RST_DLY;
			st_r.post_dly <= `BSR_RST_DLY;
			st_r.apply_dly <= `BSR_RST_DLY;
			st_r.jog_speed <= `BSR_RST_JOG;
			st_r.state <= BSR_ST_OFF;
			st_r.mode <= BSR_MODE_LATCHED;
		end else begin
			st_r <= st_nxt;
		end
	end

	// output wiring
	assign prdata = st_r.prdata;
	assign pready = st_r.pready;
	assign pslverr = st_r.pslverr;
	assign drive = st_r.drive;
	assign speed_ref = st_r.speed_ref;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	// checks
	property p_mag_start;
		st_r.state == BSR_ST_OFF && run_req && !secure_off && st_r.brake_en |=>
			st_r.state == BSR_ST_MAG && !drive.brake_release;
	endproperty
	a_mag_start: assert property (p_mag_start) else $error("magnetisation not started"); // R1
	property p_release;
		st_r.state == BSR_ST_MAG && run_req && release_ok && expired && !secure_off |=> drive.brake_release;
	endproperty
	a_release: assert property (p_release) else $error("brake not released"); // R2
	property p_ramp_mag;
		st_r.state == BSR_ST_MAG |-> drive.ramp_hold && drive.drive_enable;
	endproperty
	a_ramp_mag: assert property (p_ramp_mag) else $error("ramp not held"); // R3
	property p_pre;
		st_r.state == BSR_ST_RUN && st_r.brake_en && below_apply && !run_req && !secure_off |=>
			st_r.state == BSR_ST_PRE && drive.brake_release;
	endproperty
	a_pre: assert property (p_pre) else $error("pre-apply delay skipped"); // R4
	property p_post;
		$rose(drive.brake_release) |-> drive.ramp_hold;
	endproperty
	a_post: assert property (p_post) else $error("ramp unlocked at release"); // R5
	property p_apply_off;
		st_r.state == BSR_ST_APPLY && expired |=> !drive.drive_enable && !drive.brake_release;
	endproperty
	a_apply_off: assert property (p_apply_off) else $error("output not off"); // R6
	property p_latched;
		st_r.mode == BSR_MODE_LATCHED && contacts.contact_input_two && !contacts.contact_input_three &&
			!jog_in |=> drive.run_fwd && !drive.run_rev;
	endproperty
	a_latched: assert property (p_latched) else $error("latched forward wrong"); // R8
	property p_no_reverse;
		st_r.mode == BSR_MODE_PULSED && drive.run_rev |=> !drive.run_fwd;
	endproperty
	a_no_reverse: assert property (p_no_reverse) else $error("reversal without stop"); // R10
	property p_run_dir;
		st_r.mode == BSR_MODE_RUN_DIR && contacts.contact_input_two && contacts.contact_input_three |=>
			drive.run_rev && !drive.run_fwd;
	endproperty
	a_run_dir: assert property (p_run_dir) else $error("direction select wrong"); // R11
	property p_secure;
		secure_off |=> !drive.drive_enable;
	endproperty
	a_secure: assert property (p_secure) else $error("secure disable ignored"); // R14
	property p_hold_run;
		st_r.state == BSR_ST_RUN && below_apply && run_req && !secure_off |=>
			st_r.state == BSR_ST_RUN && drive.brake_release == st_r.brake_en;
	endproperty
	a_hold_run: assert property (p_hold_run) else $error("brake applied without stop"); // R17

	// scenarios
	c_release: cover property (st_r.state == BSR_ST_MAG ##1 st_r.state == BSR_ST_POST);
	c_apply: cover property (st_r.state == BSR_ST_APPLY ##1 st_r.state == BSR_ST_OFF);
	c_pulsed: cover property (st_r.mode == BSR_MODE_PULSED && $rose(drive.run_rev));
	c_jog: cover property ($rose(drive.jog_active));
endmodule // bsr_brake_run
`default_nettype wire

// ===== bsr_operator.sv
// contact and motor current model at the drive terminals
`default_nettype none
module bsr_operator (
	// clock
	input wire logic ref_clk,
	// drive side
	input wire bsr_pkg::bsr_drive_s drive,
	output var bsr_pkg::bsr_contacts_s contacts,
	output var logic release_ok
);
	timeunit 1ns;
	timeprecision 1ps;
	import bsr_pkg::*;

	// idle terminals at power up
	initial begin
		contacts = '0;
		release_ok = 1'b0;
	end

	// motor current is established one cycle after the stage is on
	always @(posedge ref_clk) begin
		release_ok <= drive.drive_enable;
	end

	// contacts move just after an edge, {two, three, bidir, safe}
	task put(input logic [3:0] c);
		@(posedge ref_clk);
		contacts <= c;
	endtask
endmodule // bsr_operator
`default_nettype wire

// ===== testbench.sv
// self-checking testbench for the brake sequencer and run logic
`include "bsr_defs.svh"
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import bsr_pkg::*;

	logic ref_clk;
	logic rst;
	logic [7:0] paddr;
	logic psel;
	logic penable;
	logic pwrite;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	bsr_contacts_s contacts;
	logic release_ok;
	logic below_apply;
	bsr_drive_s drive;
	logic [15:0] speed_ref;
	logic [15:0] jog;
	logic [32:0] exp_q[$];
	logic [15:0] jog_q[$];
	logic [32:0] e;
	int errors;
	int compares;
	int seed;

	// 125 MHz clock
	initial ref_clk = 1'b0;
	always #4 ref_clk = ~ref_clk;

	bsr_brake_run #(.TICK_CYCLES(4)) dut (.ref_clk(ref_clk), .rst(rst), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .contacts(contacts), .release_ok(release_ok), .below_apply(below_apply),
		.drive(drive), .speed_ref(speed_ref));

	bsr_operator op (.ref_clk(ref_clk), .drive(drive), .contacts(contacts), .release_ok(release_ok));

	task chk(input string n, input logic [32:0] x, input logic [32:0] y);
		compares++;
		if (x !== y) begin
			errors++;
			$display("unexpected %s expected %h seen %h", n, x, y);
		end
	endtask

	// scoreboard: each finished read or jog start takes the oldest note
	always @(posedge ref_clk) begin
		if (psel && penable && pready === 1'b1 && pwrite === 1'b0 && exp_q.size() > 0) begin
			e = exp_q.pop_front();
			chk("read", e, {pslverr, prdata});
		end
		if (drive.jog_active === 1'b1 && jog_q.size() > 0)
			chk("jog speed", {17'h0, jog_q.pop_front()}, {17'h0, speed_ref});
	end

	task test_done;
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// apb master: setup, access until pready, then release
	task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge ref_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		// this wait ends once pready is seen high
		do begin
			@(posedge ref_clk);
		end while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task rd(input logic [7:0] a, input logic [32:0] x);
		exp_q.push_back(x);
		apb(a, 1'b0, 32'h0);
	endtask

	// status word: state in [11:9], drive flags in [5:0]
	function automatic logic [32:0] stv(input logic [2:0] s, input logic [5:0] d);
		return {21'h0, s, 3'h0, d};
	endfunction

	task step(input logic [3:0] c, input logic [32:0] x);
		op.put(c);
		repeat (6) @(posedge ref_clk);
		rd(`BSR_OFS_STAT, x);
	endtask

	// watchdog well beyond the expected run
	initial begin
		repeat (30000) @(posedge ref_clk);
		errors++;
		test_done;
	end

	initial begin
		seed = 20897;
		rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		below_apply = 1'b1;
		repeat (12) @(posedge ref_clk);
		rst <= 1'b0;
		// reset values, unmapped and read-only places
		rd(`BSR_OFS_CTRL, 33'h0);
		for (int i = 1; i < 5; i++)
			rd(8'(4 * i), 33'h0a);
		rd(`BSR_OFS_JOG, 33'h64);
		apb(`BSR_OFS_STAT, 1'b1, 32'hfff);
		rd(`BSR_OFS_STAT, 33'h0);
		rd(8'h1c, {1'b1, 32'h0});
		// latched mode with plain unlock input: command decoded, output on only while the unlock input is high
		step(4'b1000, 33'h04);
		step(4'b1001, stv(BSR_ST_RUN, 6'h0c));
		apb(`BSR_OFS_CTRL, 1'b1, 32'h0a);
		rd(`BSR_OFS_CTRL, 33'h0);
		step(4'b1101, 33'h0);
		step(4'b0101, stv(BSR_ST_RUN, 6'h0a));
		step(4'b0001, 33'h0);
		// secure disable setting
		apb(`BSR_OFS_CTRL, 1'b1, 32'h08);
		rd(`BSR_OFS_CTRL, 33'h08);
		step(4'b1001, stv(BSR_ST_RUN, 6'h0c));
		step(4'b1000, 33'h04);
		// pulsed mode, reversal only after stop; clear the leftover command first
		apb(`BSR_OFS_CTRL, 1'b1, 32'h02);
		step(4'b0101, 33'h0);
		step(4'b1001, stv(BSR_ST_RUN, 6'h0c));
		step(4'b0001, stv(BSR_ST_RUN, 6'h0c));
		step(4'b0011, stv(BSR_ST_RUN, 6'h0c));
		step(4'b0101, 33'h0);
		step(4'b0011, stv(BSR_ST_RUN, 6'h0a));
		step(4'b0001, stv(BSR_ST_RUN, 6'h0a));
		step(4'b0101, 33'h0);
		// run plus direction mode, then the spare code
		apb(`BSR_OFS_CTRL, 1'b1, 32'h04);
		step(4'b1001, stv(BSR_ST_RUN, 6'h0c));
		step(4'b1101, stv(BSR_ST_RUN, 6'h0a));
		step(4'b0101, 33'h0);
		apb(`BSR_OFS_CTRL, 1'b1, 32'h06);
		step(4'b1001, 33'h0);
		step(4'b0001, 33'h0);
		// jog on the bidirectional line
		jog = 16'($random(seed));
		apb(`BSR_OFS_CTRL, 1'b1, 32'h10);
		apb(`BSR_OFS_JOG, 1'b1, {16'h0, jog});
		rd(`BSR_OFS_JOG, {17'h0, jog});
		jog_q.push_back(jog);
		step(4'b0011, stv(BSR_ST_RUN, 6'h0d));
		step(4'b0001, 33'h0);
		// full brake sequence, every delay 20 ticks
		for (int i = 1; i < 5; i++)
			apb(8'(4 * i), 1'b1, 32'h14);
		apb(`BSR_OFS_CTRL, 1'b1, 32'h01);
		below_apply <= 1'b0;
		step(4'b1001, stv(BSR_ST_MAG, 6'h1c));
		repeat (100) @(posedge ref_clk);
		rd(`BSR_OFS_STAT, stv(BSR_ST_POST, 6'h3c));
		repeat (100) @(posedge ref_clk);
		rd(`BSR_OFS_STAT, stv(BSR_ST_RUN, 6'h2c));
		below_apply <= 1'b1;
		step(4'b1001, stv(BSR_ST_RUN, 6'h2c));
		step(4'b0001, stv(BSR_ST_PRE, 6'h28));
		repeat (100) @(posedge ref_clk);
		rd(`BSR_OFS_STAT, stv(BSR_ST_APPLY, 6'h08));
		repeat (100) @(posedge ref_clk);
		rd(`BSR_OFS_STAT, 33'h0);
		repeat (4) @(posedge ref_clk);
		test_done;
	end
endmodule // testbench
`default_nettype wire
